// ===== verilog/pgnr_request_framer.sv
// parameter-group request framer with reply and transport formatting
`timescale 1ns/100ps
module pgnr_request_framer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host commands
  input wire logic i_cmd_valid,
  input wire pgnr_pkg::pgnr_cmd_s i_cmd,
  output logic o_cmd_ready,
  input wire logic i_stop,
  // display options
  input wire logic i_headers_on,
  input wire logic i_auto_format_off,
  // bus transmit
  output logic o_tx_valid,
  output pgnr_pkg::pgnr_frame_s o_tx_frame,
  input wire logic i_tx_ready,
  // bus receive
  input wire logic i_rx_valid,
  input wire pgnr_pkg::pgnr_frame_s i_rx_frame,
  output logic o_rx_ready,
  // text out
  output logic o_chr_valid,
  output logic [7:0] o_chr,
  input wire logic i_chr_ready,
  // status
  output logic o_busy
);
  pgnr_pkg::pgnr_state_e state_reg;
  logic [2:0] prio_reg;
  logic [7:0] pf_reg;
  logic [7:0] da_reg;
  logic [7:0] sa_reg;
  logic keep_order_reg;
  logic [23:0] pgn_reg;
  logic mon_reg;
  logic [3:0] count_reg;
  logic [3:0] msg_cnt_reg;
  logic tp_act_reg;
  logic tp_rts_reg;
  logic [7:0] tp_src_reg;
  logic [7:0] tp_pkts_reg;
  logic tx_pend_reg;
  pgnr_pkg::pgnr_frame_s tx_frame_reg;
  logic line_pend_reg;
  pgnr_pkg::pgnr_line_s line_reg;
  logic emit_ready;

  function automatic logic [28:0] mk_id(input logic [2:0] p, input logic [7:0] f,
                                        input logic [7:0] d, input logic [7:0] s);
    mk_id = {p, pgnr_pkg::DP_ZERO, f, d, s};
  endfunction

  function automatic logic [23:0] frame_pgn(input logic [28:0] id);
    frame_pgn = (id[23:16] >= pgnr_pkg::PF_PDU2) ? {6'h00, id[25:8]}
                                                : {6'h00, id[25:16], pgnr_pkg::BYTE_ZERO};
  endfunction

  // transport control frame toward the sender
  function automatic pgnr_pkg::pgnr_frame_s mk_tp(input logic [2:0] p, input logic [7:0] d,
      input logic [7:0] s, input logic [0:7][7:0] b);
    mk_tp.id = mk_id(p, pgnr_pkg::PF_TPCM, d, s);
    mk_tp.dlc = pgnr_pkg::FULL_DLC;
    mk_tp.data = b;
  endfunction

  // receive classification
  logic cmd_fire;
  logic rx_fire;
  logic [7:0] f_pf;
  logic [7:0] f_ps;
  logic [7:0] f_sa;
  logic [23:0] emb_pgn;
  logic src_ok;
  logic is_cm;
  logic is_dt;
  logic is_ack;
  logic is_dir;
  logic take;
  logic msg_done;
  logic tp_last;
  logic cnt_hit;
  logic [3:0] cnt_inc;
  logic [23:0] mon_pgn;

  assign cmd_fire = i_cmd_valid && o_cmd_ready;
  assign rx_fire = i_rx_valid && o_rx_ready;
  assign f_pf = i_rx_frame.id[23:16];
  assign f_ps = i_rx_frame.id[15:8];
  assign f_sa = i_rx_frame.id[7:0];
  assign emb_pgn = {i_rx_frame.data[7], i_rx_frame.data[6], i_rx_frame.data[5]};
  assign src_ok = mon_reg || (da_reg == pgnr_pkg::DA_GLOBAL) || (f_sa == da_reg);
  assign is_cm = (f_pf == pgnr_pkg::PF_TPCM) && (emb_pgn == pgn_reg) &&
                 ((i_rx_frame.data[0] == pgnr_pkg::CM_RTS && f_ps == sa_reg) ||
                  i_rx_frame.data[0] == pgnr_pkg::CM_BAM);
  assign is_dt = (f_pf == pgnr_pkg::PF_TPDT) && tp_act_reg && (f_sa == tp_src_reg);
  assign is_ack = !mon_reg && (f_pf == pgnr_pkg::PF_ACK) && (emb_pgn == pgn_reg);
  assign is_dir = (frame_pgn(i_rx_frame.id) == pgn_reg);
  assign take = src_ok && (is_cm || is_dt || is_ack || is_dir);
  assign tp_last = is_dt && (i_rx_frame.data[0] == tp_pkts_reg);
  assign msg_done = take && !is_cm && (!is_dt || tp_last);
  assign cnt_inc = 4'(msg_cnt_reg + 4'h1);
  assign cnt_hit = msg_done && (count_reg != 4'h0) && (cnt_inc == count_reg);

  // short monitor forms
  always_comb begin
    if (i_cmd.ndig == pgnr_pkg::DIG_SIX) begin
      mon_pgn = i_cmd.arg;
    end else if (i_cmd.ndig == pgnr_pkg::DIG_FIVE) begin
      mon_pgn = {pgnr_pkg::BYTE_ZERO, i_cmd.arg[19:4]};
    end else begin
      mon_pgn = {pgnr_pkg::BYTE_ZERO, i_cmd.arg[15:0]};
    end
  end

  assign o_cmd_ready = (state_reg == pgnr_pkg::ST_IDLE) && !tx_pend_reg;
  assign o_rx_ready = (state_reg == pgnr_pkg::ST_LISTEN) && !line_pend_reg && !tx_pend_reg;
  assign o_tx_valid = tx_pend_reg;
  assign o_tx_frame = tx_frame_reg;
  assign o_busy = (state_reg != pgnr_pkg::ST_IDLE);

  // sequencing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= pgnr_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        pgnr_pkg::ST_IDLE: begin
          if (cmd_fire && (i_cmd.op == pgnr_pkg::OP_REQUEST ||
                           i_cmd.op == pgnr_pkg::OP_MONITOR)) begin
            state_reg <= pgnr_pkg::ST_LISTEN;
          end
        end
        pgnr_pkg::ST_LISTEN: begin
          if (i_stop || (rx_fire && cnt_hit)) begin
            state_reg <= pgnr_pkg::ST_PROMPT;
          end
        end
        pgnr_pkg::ST_PROMPT: begin
          if (!line_pend_reg && !tx_pend_reg) begin
            state_reg <= pgnr_pkg::ST_FINISH;
          end
        end
        pgnr_pkg::ST_FINISH: begin
          if (!line_pend_reg && emit_ready) begin
            state_reg <= pgnr_pkg::ST_IDLE;
          end
        end
        default: state_reg <= pgnr_pkg::ST_IDLE;
      endcase
    end
  end

  // identifier configuration
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prio_reg <= pgnr_pkg::PRIO_DEF;
      pf_reg <= pgnr_pkg::PF_REQ;
      da_reg <= pgnr_pkg::DA_GLOBAL;
      sa_reg <= pgnr_pkg::SA_DEF;
      keep_order_reg <= 1'b0;
    end else if (cmd_fire) begin
      case (i_cmd.op)
        pgnr_pkg::OP_KEEP_ORDER: keep_order_reg <= i_cmd.arg[0];
        pgnr_pkg::OP_HEADER_SET: begin
          pf_reg <= i_cmd.arg[23:16];
          da_reg <= i_cmd.arg[15:8];
          sa_reg <= i_cmd.arg[7:0];
        end
        pgnr_pkg::OP_PRIORITY_SET: prio_reg <= i_cmd.arg[2:0];
        default: prio_reg <= prio_reg;
      endcase
    end
  end

  // active request or monitor
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pgn_reg <= 24'h000000;
      mon_reg <= 1'b0;
      count_reg <= 4'h0;
      msg_cnt_reg <= 4'h0;
    end else if (cmd_fire && i_cmd.op == pgnr_pkg::OP_REQUEST) begin
      pgn_reg <= i_cmd.arg;
      mon_reg <= 1'b0;
      count_reg <= 4'h0;
      msg_cnt_reg <= 4'h0;
    end else if (cmd_fire && i_cmd.op == pgnr_pkg::OP_MONITOR) begin
      pgn_reg <= mon_pgn;
      mon_reg <= 1'b1;
      count_reg <= i_cmd.count;
      msg_cnt_reg <= 4'h0;
    end else if (rx_fire && msg_done) begin
      msg_cnt_reg <= cnt_inc;
    end
  end

  // transport session
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tp_act_reg <= 1'b0;
      tp_rts_reg <= 1'b0;
      tp_src_reg <= 8'h00;
      tp_pkts_reg <= 8'h00;
    end else if (cmd_fire) begin
      tp_act_reg <= 1'b0;
    end else if (rx_fire && take && is_cm) begin
      tp_act_reg <= 1'b1;
      tp_rts_reg <= (i_rx_frame.data[0] == pgnr_pkg::CM_RTS);
      tp_src_reg <= f_sa;
      tp_pkts_reg <= i_rx_frame.data[3];
    end else if (rx_fire && take && tp_last) begin
      tp_act_reg <= 1'b0;
    end
  end

  // bus transmit: request, clear-to-send, end-of-message ack
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_pend_reg <= 1'b0;
      tx_frame_reg <= '0;
    end else if (cmd_fire && i_cmd.op == pgnr_pkg::OP_REQUEST) begin
      tx_pend_reg <= 1'b1;
      tx_frame_reg.id <= mk_id(prio_reg, pf_reg, da_reg, sa_reg);
      tx_frame_reg.dlc <= pgnr_pkg::REQ_DLC;
      tx_frame_reg.data <= '0;
      if (keep_order_reg) begin
        tx_frame_reg.data[0:2] <= {i_cmd.arg[23:16], i_cmd.arg[15:8], i_cmd.arg[7:0]};
      end else begin
        tx_frame_reg.data[0:2] <= {i_cmd.arg[7:0], i_cmd.arg[15:8], i_cmd.arg[23:16]};
      end
    end else if (rx_fire && take && is_cm && i_rx_frame.data[0] == pgnr_pkg::CM_RTS) begin
      tx_pend_reg <= 1'b1;
      tx_frame_reg <= mk_tp(prio_reg, f_sa, sa_reg, {pgnr_pkg::CM_CTS, i_rx_frame.data[3],
                           pgnr_pkg::SEQ_FIRST, pgnr_pkg::PAD_BYTE, pgnr_pkg::PAD_BYTE,
                           i_rx_frame.data[5], i_rx_frame.data[6], i_rx_frame.data[7]});
    end else if (rx_fire && take && tp_last && tp_rts_reg) begin
      tx_pend_reg <= 1'b1;
      tx_frame_reg <= mk_tp(prio_reg, f_sa, sa_reg, {pgnr_pkg::CM_EOMA, line_reg.size[7:0],
                           4'h0, line_reg.size[11:8], tp_pkts_reg, pgnr_pkg::PAD_BYTE,
                           pgn_reg[7:0], pgn_reg[15:8], pgn_reg[23:16]});
    end else if (tx_pend_reg && i_tx_ready) begin
      tx_pend_reg <= 1'b0;
    end
  end

  // line descriptors toward the text emitter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      line_pend_reg <= 1'b0;
      line_reg <= '0;
    end else if (rx_fire && take) begin
      line_pend_reg <= 1'b1;
      line_reg.frame <= i_rx_frame;
      line_reg.prompt <= 1'b0;
      line_reg.head_on <= i_headers_on;
      line_reg.size_only <= is_cm && !i_auto_format_off;
      line_reg.seg_on <= is_dt && !i_headers_on;
      line_reg.nbytes <= (is_dt && !i_headers_on) ? pgnr_pkg::SEG_DATA : i_rx_frame.dlc;
      if (is_cm) begin
        line_reg.size <= {i_rx_frame.data[2][3:0], i_rx_frame.data[1]};
      end
    end else if (state_reg == pgnr_pkg::ST_PROMPT && !line_pend_reg && !tx_pend_reg) begin
      line_pend_reg <= 1'b1;
      line_reg.prompt <= 1'b1;
    end else if (line_pend_reg && emit_ready) begin
      line_pend_reg <= 1'b0;
    end
  end

  pgnr_line_emit u_emit (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_line_valid(line_pend_reg),
    .i_line(line_reg),
    .o_line_ready(emit_ready),
    .o_chr_valid(o_chr_valid),
    .o_chr(o_chr),
    .i_chr_ready(i_chr_ready)
  );
endmodule // pgnr_request_framer

// ===== include/pgnr_pkg.sv
// constants and types for the parameter-group request framer
package pgnr_pkg;
  // identifier defaults and format codes
  localparam logic [2:0] PRIO_DEF = 3'h6;
  localparam logic [7:0] PF_REQ = 8'hea;
  localparam logic [7:0] DA_GLOBAL = 8'hff;
  localparam logic [7:0] SA_DEF = 8'hf9;
  localparam logic [7:0] PF_ACK = 8'he8;
  localparam logic [7:0] PF_TPCM = 8'hec;
  localparam logic [7:0] PF_TPDT = 8'heb;
  localparam logic [7:0] PF_PDU2 = 8'hf0;
  localparam logic [1:0] DP_ZERO = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'hff;
  localparam logic [3:0] REQ_DLC = 4'h3;
  localparam logic [3:0] FULL_DLC = 4'h8;
  localparam logic [3:0] SEG_DATA = 4'h7;
  // transport control bytes
  localparam logic [7:0] CM_RTS = 8'h10;
  localparam logic [7:0] CM_CTS = 8'h11;
  localparam logic [7:0] CM_EOMA = 8'h13;
  localparam logic [7:0] CM_BAM = 8'h20;
  localparam logic [7:0] SEQ_FIRST = 8'h01;
  // text characters
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_PROMPT = 8'h3e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A_OFS = 8'h57;
  // line layout positions
  localparam logic [5:0] HEAD_LEN = 6'h0b;
  localparam logic [5:0] SEG_LEN = 6'h04;
  localparam logic [5:0] SIZE_LEN = 6'h03;
  // monitor digit counts
  localparam logic [2:0] DIG_FIVE = 3'h5;
  localparam logic [2:0] DIG_SIX = 3'h6;

  typedef enum logic [2:0] {
    OP_REQUEST,
    OP_KEEP_ORDER,
    OP_HEADER_SET,
    OP_PRIORITY_SET,
    OP_MONITOR
  } pgnr_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LISTEN,
    ST_PROMPT,
    ST_FINISH
  } pgnr_state_e;

  typedef struct packed {
    pgnr_op_e op;
    logic [23:0] arg;
    logic [2:0] ndig;
    logic [3:0] count;
  } pgnr_cmd_s;

  typedef struct packed {
    logic [28:0] id;
    logic [3:0] dlc;
    logic [0:7][7:0] data;
  } pgnr_frame_s;

  typedef struct packed {
    logic head_on;
    logic size_only;
    logic prompt;
    logic seg_on;
    logic [3:0] nbytes;
    logic [11:0] size;
    pgnr_frame_s frame;
  } pgnr_line_s;
endpackage

// ===== verilog/pgnr_line_emit.sv
// turns one line descriptor into a stream of text characters
`timescale 1ns/100ps
module pgnr_line_emit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // line in
  input wire logic i_line_valid,
  input wire pgnr_pkg::pgnr_line_s i_line,
  output logic o_line_ready,
  // characters out
  output logic o_chr_valid,
  output logic [7:0] o_chr,
  input wire logic i_chr_ready
);
  logic active_reg;
  logic [5:0] pos_reg;
  logic [7:0] chr_reg;
  logic last_reg;
  pgnr_pkg::pgnr_line_s line_reg;
  logic [8:0] first_c;
  logic [8:0] next_c;

  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'ha) ? pgnr_pkg::CH_ZERO + {4'h0, n} : pgnr_pkg::CH_A_OFS + {4'h0, n};
  endfunction

  // returns {last, character} at position p
  function automatic logic [8:0] char_at(input pgnr_pkg::pgnr_line_s l, input logic [5:0] p);
    logic [5:0] base;
    logic [5:0] rel;
    logic [5:0] k;
    logic [1:0] r;
    logic [2:0] idx;
    logic [7:0] b;
    logic [28:0] id;
    base = l.head_on ? pgnr_pkg::HEAD_LEN : (l.seg_on ? pgnr_pkg::SEG_LEN : 6'h00);
    rel = p - base;
    k = rel / 6'h03;
    r = 2'(rel % 6'h03);
    idx = 3'(k + {5'h00, l.seg_on});
    b = l.frame.data[idx];
    id = l.frame.id;
    char_at = {1'b0, pgnr_pkg::CH_SP};
    if (l.prompt) begin
      char_at = {1'b1, pgnr_pkg::CH_PROMPT};
    end else if (l.size_only) begin
      if (p < pgnr_pkg::SIZE_LEN) begin
        char_at = {1'b0, hexc(4'(l.size >> (4'h8 - {p[1:0], 2'h0})))};
      end else begin
        char_at = {1'b1, pgnr_pkg::CH_CR};
      end
    end else if (p < base && l.head_on) begin
      case (p)
        6'h00: char_at = {1'b0, hexc({1'b0, id[28:26]})};
        6'h02: char_at = {1'b0, hexc({2'h0, id[25:24]})};
        6'h03: char_at = {1'b0, hexc(id[23:20])};
        6'h04: char_at = {1'b0, hexc(id[19:16])};
        6'h05: char_at = {1'b0, hexc(id[15:12])};
        6'h06: char_at = {1'b0, hexc(id[11:8])};
        6'h08: char_at = {1'b0, hexc(id[7:4])};
        6'h09: char_at = {1'b0, hexc(id[3:0])};
        default: char_at = {1'b0, pgnr_pkg::CH_SP};
      endcase
    end else if (p < base) begin
      case (p)
        6'h00: char_at = {1'b0, hexc(l.frame.data[0][7:4])};
        6'h01: char_at = {1'b0, hexc(l.frame.data[0][3:0])};
        6'h02: char_at = {1'b0, pgnr_pkg::CH_COLON};
        default: char_at = {1'b0, pgnr_pkg::CH_SP};
      endcase
    end else if (l.nbytes == 4'h0) begin
      char_at = {1'b1, pgnr_pkg::CH_CR};
    end else begin
      case (r)
        2'h0: char_at = {1'b0, hexc(b[7:4])};
        2'h1: char_at = {1'b0, hexc(b[3:0])};
        default: begin
          if (k == 6'(l.nbytes - 4'h1)) begin
            char_at = {1'b1, pgnr_pkg::CH_CR};
          end else begin
            char_at = {1'b0, pgnr_pkg::CH_SP};
          end
        end
      endcase
    end
  endfunction

  assign first_c = char_at(i_line, 6'h00);
  assign next_c = char_at(line_reg, 6'(pos_reg + 6'h01));
  assign o_line_ready = !active_reg;
  assign o_chr_valid = active_reg;
  assign o_chr = chr_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      active_reg <= 1'b0;
      pos_reg <= 6'h00;
      chr_reg <= 8'h00;
      last_reg <= 1'b0;
      line_reg <= '0;
    end else if (!active_reg && i_line_valid) begin
      active_reg <= 1'b1;
      pos_reg <= 6'h00;
      line_reg <= i_line;
      chr_reg <= first_c[7:0];
      last_reg <= first_c[8];
    end else if (active_reg && i_chr_ready) begin
      if (last_reg) begin
        active_reg <= 1'b0;
      end else begin
        pos_reg <= 6'(pos_reg + 6'h01);
        chr_reg <= next_c[7:0];
        last_reg <= next_c[8];
      end
    end
  end
endmodule // pgnr_line_emit

// ===== dv/pgnr_asserts.sv
// port assertions for the request framer
`timescale 1ns/100ps
module pgnr_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic i_cmd_valid,
  input wire pgnr_pkg::pgnr_cmd_s i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_tx_valid,
  input wire pgnr_pkg::pgnr_frame_s o_tx_frame,
  input wire logic i_tx_ready,
  input wire logic o_rx_ready,
  input wire logic o_chr_valid,
  input wire logic [7:0] o_chr,
  input wire logic i_chr_ready,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic take;
  logic cts;
  logic prm;
  assign take = i_cmd_valid && o_cmd_ready;
  assign cts = o_tx_valid && o_tx_frame.id[23:16] == pgnr_pkg::PF_TPCM;
  assign prm = o_chr_valid && i_chr_ready && o_chr == pgnr_pkg::CH_PROMPT;
  chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_frame))
    else $error("transmit frame changed before accept");
  chk_chr_hold: assert property (o_chr_valid && !i_chr_ready |=> o_chr_valid && $stable(o_chr))
    else $error("character changed before accept");
  chk_req_frame: assert property (take && i_cmd.op == pgnr_pkg::OP_REQUEST |=> o_tx_valid && o_tx_frame.dlc == pgnr_pkg::REQ_DLC)
    else $error("request frame not three bytes");
  chk_busy_refuse: assert property (o_busy |-> !o_cmd_ready)
    else $error("command ready while busy");
  chk_rx_gate: assert property (o_rx_ready |-> o_busy && !o_tx_valid)
    else $error("receive ready outside listening");
  chk_cts_full: assert property (cts |-> o_tx_frame.dlc == pgnr_pkg::FULL_DLC && o_tx_frame.data[4] == pgnr_pkg::PAD_BYTE)
    else $error("transport control frame malformed");
  chk_reset_idle: assert property ($fell(i_rst) |-> !o_busy && !o_tx_valid && !o_chr_valid && o_cmd_ready)
    else $error("outputs not idle after reset");
  chk_cfg_quiet: assert property (take && i_cmd.op inside {pgnr_pkg::OP_KEEP_ORDER, pgnr_pkg::OP_HEADER_SET, pgnr_pkg::OP_PRIORITY_SET} |=> !o_tx_valid && !o_busy)
    else $error("config command started traffic");
  chk_prompt_end: assert property (o_busy && prm |-> ##[1:4] !o_busy)
    else $error("still busy after prompt");
  cov_req: cover property (take && i_cmd.op == pgnr_pkg::OP_REQUEST);
  cov_cts: cover property (cts && i_tx_ready);
  cov_prompt: cover property (prm);
endmodule // pgnr_asserts
bind pgnr_request_framer pgnr_asserts u_chk (.i_clk, .i_rst, .i_cmd_valid, .i_cmd, .o_cmd_ready,
  .o_tx_valid, .o_tx_frame, .i_tx_ready, .o_rx_ready, .o_chr_valid, .o_chr, .i_chr_ready, .o_busy);

// ===== dv/pgnr_ecu_model.sv
// behavioural control units on the bus side
`timescale 1ns/100ps
module pgnr_ecu_model (
  // clock and scenario control
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [1:0] i_mode,
  // frames from the framer
  input wire logic i_tx_valid,
  input wire pgnr_pkg::pgnr_frame_s i_tx_frame,
  output logic o_tx_ready,
  // frames to the framer
  output logic o_rx_valid,
  output pgnr_pkg::pgnr_frame_s o_rx_frame,
  input wire logic i_rx_ready
);
  pgnr_pkg::pgnr_frame_s q[$];
  logic [23:0] pgn;
  function automatic pgnr_pkg::pgnr_frame_s mk(input logic [2:0] p, input logic [1:0] dp,
      input logic [7:0] f, input logic [7:0] s, input logic [63:0] d);
    mk = '{{p, dp, f, s, 8'h00}, pgnr_pkg::FULL_DLC, d};
  endfunction
  task automatic push(input pgnr_pkg::pgnr_frame_s f);
    q.push_back(f);
  endtask
  initial begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_frame = '0;
  end
  always @(posedge i_clk) begin
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
    pgn = {i_tx_frame.data[2], i_tx_frame.data[1], i_tx_frame.data[0]};
    if (i_tx_valid && o_tx_ready && i_tx_frame.id[23:16] == pgnr_pkg::PF_REQ) begin
      case (i_mode)
        2'd0: push(mk(3'h6, pgn[17:16], pgn[15:8], pgn[7:0], 64'h80841e00ffffffff));
        2'd1: push(mk(3'h6, 2'h0, 8'he8, 8'hff, {40'h01ffffffff, pgn[7:0], pgn[15:8], pgn[23:16]}));
        2'd2: push(mk(3'h7, 2'h0, 8'hec, 8'hf9, 64'h10120003ffcbfe00));
        default: ;
      endcase
    end else if (i_tx_valid && o_tx_ready && i_tx_frame.data[0] == pgnr_pkg::CM_CTS) begin
      push(mk(3'h7, 2'h0, 8'heb, 8'hf9, 64'h0104ff5000040b54));
      push(mk(3'h7, 2'h0, 8'heb, 8'hf9, 64'h020000015f050231));
      push(mk(3'h7, 2'h0, 8'heb, 8'hf9, 64'h036d050303ffffff));
    end
    if (o_rx_valid && i_rx_ready) begin
      o_rx_valid <= 1'b0;
      o_rx_frame <= ~o_rx_frame;
    end else if (!o_rx_valid && q.size() > 0) begin
      o_rx_valid <= 1'b1;
      o_rx_frame <= q.pop_front();
    end
  end
endmodule // pgnr_ecu_model

// ===== dv/tb.sv
// self-checking bench for the request framer
`timescale 1ns/100ps
module tb;
  logic i_clk, i_rst, i_cmd_valid, i_stop, i_headers_on, i_auto_format_off;
  logic o_cmd_ready, o_tx_valid, i_tx_ready, i_rx_valid, o_rx_ready;
  logic o_chr_valid, i_chr_ready, o_busy, slow;
  logic [1:0] mode;
  logic [7:0] o_chr;
  pgnr_pkg::pgnr_cmd_s i_cmd;
  pgnr_pkg::pgnr_frame_s o_tx_frame, i_rx_frame;
  pgnr_pkg::pgnr_frame_s tx_q[$];
  logic [7:0] txt_q[$];
  int bad_count, cmp_count;
  string ln = "6 0fee5 00 80 84 1e 00 ff ff ff ff\015";
  string seg = {"01: 04 ff 50 00 04 0b 54\01502: 00 00 01 5f 05 02 31\015",
    "03: 6d 05 03 03 ff ff ff\015"};
  pgnr_request_framer u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_stop(i_stop), .i_headers_on(i_headers_on),
    .i_auto_format_off(i_auto_format_off), .o_tx_valid(o_tx_valid), .o_tx_frame(o_tx_frame),
    .i_tx_ready(i_tx_ready), .i_rx_valid(i_rx_valid), .i_rx_frame(i_rx_frame),
    .o_rx_ready(o_rx_ready), .o_chr_valid(o_chr_valid), .o_chr(o_chr),
    .i_chr_ready(i_chr_ready), .o_busy(o_busy));
  pgnr_ecu_model u_ecu (.i_clk(i_clk), .i_slow(slow), .i_mode(mode), .i_tx_valid(o_tx_valid),
    .i_tx_frame(o_tx_frame), .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid),
    .o_rx_frame(i_rx_frame), .i_rx_ready(o_rx_ready));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(negedge i_clk) i_chr_ready <= ~i_chr_ready;
  always @(posedge i_clk) begin
    if (o_tx_valid && i_tx_ready) tx_q.push_back(o_tx_frame);
    if (o_chr_valid && i_chr_ready) txt_q.push_back(o_chr);
  end
  task automatic cmp_v(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input pgnr_pkg::pgnr_op_e op, input logic [23:0] a,
      input logic [2:0] nd, input logic [3:0] cnt);
    int n;
    n = 0;
    @(negedge i_clk);
    i_cmd = '{op, a, nd, cnt};
    i_cmd_valid = 1'b1;
    while (o_cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask
  task automatic chk_frame(input logic [28:0] id, input logic [63:0] d, input logic [3:0] dlc,
      input logic [28:0] m = '1);
    int n;
    pgnr_pkg::pgnr_frame_s f;
    n = 0;
    while (tx_q.size() == 0 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    f = (tx_q.size() > 0) ? tx_q.pop_front() : '0;
    cmp_v(f.id & m, id & m);
    cmp_v(f.dlc, dlc);
    cmp_v(64'(f.data) >> (8 * (8 - dlc)), d);
  endtask
  task automatic chk_text(input string s);
    int n;
    n = 0;
    while (txt_q.size() < s.len() && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    cmp_v(txt_q.size() >= s.len(), 1);
    for (int i = 0; i < s.len() && txt_q.size() > 0; i++) cmp_v(txt_q.pop_front(), s[i]);
  endtask
  task automatic stop_session();
    int n;
    n = 0;
    @(negedge i_clk);
    i_stop = 1'b1;
    while (o_busy !== 1'b0 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    i_stop = 1'b0;
    chk_text(">");
  endtask
  task automatic t_direct();
    i_headers_on = 1'b1;
    slow = 1'b1;
    mode = 2'd0;
    cmd(pgnr_pkg::OP_REQUEST, 24'h00fee5, 3'h6, 4'h0);
    chk_frame({3'h6, 2'h0, 8'hea, 8'hff, 8'hf9}, 64'he5fe00, 4'h3);
    chk_text(ln);
    stop_session();
    slow = 1'b0;
    $display("t_direct done");
  endtask
  task automatic t_nack();
    mode = 2'd1;
    cmd(pgnr_pkg::OP_HEADER_SET, 24'hea00f9, 3'h0, 4'h0);
    cmd(pgnr_pkg::OP_REQUEST, 24'h00feee, 3'h6, 4'h0);
    chk_frame({3'h6, 2'h0, 8'hea, 8'h00, 8'hf9}, 64'heefe00, 4'h3);
    chk_text("6 0e8ff 00 01 ff ff ff ff ee fe 00\015");
    stop_session();
    $display("t_nack done");
  endtask
  task automatic t_order();
    mode = 2'd3;
    cmd(pgnr_pkg::OP_PRIORITY_SET, 24'h000003, 3'h0, 4'h0);
    cmd(pgnr_pkg::OP_HEADER_SET, 24'heaff2a, 3'h0, 4'h0);
    cmd(pgnr_pkg::OP_KEEP_ORDER, 24'h000001, 3'h0, 4'h0);
    cmd(pgnr_pkg::OP_REQUEST, 24'h00feee, 3'h6, 4'h0);
    chk_frame({3'h3, 2'h0, 8'hea, 8'hff, 8'h2a}, 64'h00feee, 4'h3);
    stop_session();
    cmd(pgnr_pkg::OP_KEEP_ORDER, 24'h000000, 3'h0, 4'h0);
    cmd(pgnr_pkg::OP_PRIORITY_SET, 24'h000006, 3'h0, 4'h0);
    cmd(pgnr_pkg::OP_HEADER_SET, 24'heafff9, 3'h0, 4'h0);
    $display("t_order done");
  endtask
  task automatic t_transport();
    i_headers_on = 1'b0;
    mode = 2'd2;
    cmd(pgnr_pkg::OP_REQUEST, 24'h00fecb, 3'h6, 4'h0);
    chk_frame({3'h6, 2'h0, 8'hea, 8'hff, 8'hf9}, 64'hcbfe00, 4'h3);
    chk_frame({8'hec, 8'h00, 8'hf9}, 64'h110301ffffcbfe00, 4'h8, 29'hffffff);
    chk_frame({8'hec, 8'h00, 8'hf9}, 64'h13120003ffcbfe00, 4'h8, 29'hffffff);
    chk_text({"012\015", seg});
    stop_session();
    $display("t_transport done");
  endtask
  task automatic t_cm_full();
    i_auto_format_off = 1'b1;
    cmd(pgnr_pkg::OP_REQUEST, 24'h00fecb, 3'h6, 4'h0);
    chk_frame({3'h6, 2'h0, 8'hea, 8'hff, 8'hf9}, 64'hcbfe00, 4'h3);
    chk_frame({8'hec, 8'h00, 8'hf9}, 64'h110301ffffcbfe00, 4'h8, 29'hffffff);
    chk_frame({8'hec, 8'h00, 8'hf9}, 64'h13120003ffcbfe00, 4'h8, 29'hffffff);
    chk_text({"10 12 00 03 ff cb fe 00\015", seg});
    stop_session();
    i_auto_format_off = 1'b0;
    $display("t_cm_full done");
  endtask
  task automatic t_monitor();
    i_headers_on = 1'b1;
    cmd(pgnr_pkg::OP_MONITOR, 24'h0fee50, 3'h5, 4'h2);
    u_ecu.push(u_ecu.mk(3'h6, 2'h0, 8'hfe, 8'hca, 64'h80841e00ffffffff));
    u_ecu.push(u_ecu.mk(3'h6, 2'h0, 8'hfe, 8'he5, 64'h80841e00ffffffff));
    u_ecu.push(u_ecu.mk(3'h6, 2'h0, 8'hfe, 8'he5, 64'h80841e00ffffffff));
    chk_text({ln, ln, ">"});
    cmd(pgnr_pkg::OP_MONITOR, 24'h00fee5, 3'h4, 4'h1);
    u_ecu.push(u_ecu.mk(3'h6, 2'h0, 8'hfe, 8'he5, 64'h80841e00ffffffff));
    chk_text({ln, ">"});
    repeat (8) @(negedge i_clk);
    cmp_v(o_busy, 0);
    $display("t_monitor done");
  endtask
  task automatic complete_run();
    $display("counts bad=%0d cmp=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    bad_count++;
    complete_run();
  end
  initial begin
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    i_stop = 1'b0;
    i_headers_on = 1'b0;
    i_auto_format_off = 1'b0;
    i_chr_ready = 1'b0;
    slow = 1'b0;
    mode = 2'd0;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    cmp_v(o_cmd_ready, 1);
    cmp_v(o_busy, 0);
    $display("t_reset done");
    t_direct();
    t_nack();
    t_order();
    t_transport();
    t_cm_full();
    t_monitor();
    complete_run();
  end
endmodule // tb
